// File: csu_pkg.sv
// shared constants and carrier types for the chip select unit
// assumes one 100 MHz clock; the processor bus clock runs at half that rate
`default_nettype none
package csu_pkg;

  // clock figures
  localparam int unsigned CLK_PERIOD_PS   = 10000;  // aclk period, 10 ns
  localparam int unsigned BUS_CLK_DIV     = 2;      // aclk cycles per processor bus clock
  localparam int unsigned RFSH_ACTIVE_X10 = 15;     // refresh pulse, 1.5 bus clock periods
  // refresh pulse length in aclk cycles, rounded up
  localparam int unsigned RFSH_ACTIVE_CYCLES = (RFSH_ACTIVE_X10 * BUS_CLK_DIV + 9) / 10;

  // register byte offsets
  localparam logic [7:0] OFS_AUX_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_REFRESH_CTRL = 8'h04;
  localparam logic [7:0] OFS_MID_PERIPH   = 8'h08;
  localparam logic [7:0] OFS_MID_CFG      = 8'h0C;
  localparam logic [7:0] OFS_PERIPH_CFG   = 8'h10;
  localparam logic [7:0] OFS_STATUS       = 8'h14;

  // field positions
  localparam int unsigned AUX_MID_WIDE_BIT  = 1;   // midrange data width 16 when set
  localparam int unsigned RFC_MODE_BIT      = 15;  // pseudo-static / dynamic refresh mode
  localparam int unsigned RFC_IVL_W         = 9;   // refresh interval field [8:0]
  localparam int unsigned MPA_LATCH_OPT_BIT = 7;   // 0: latched address bits on pins
  localparam int unsigned MPA_PER_MEM_BIT   = 6;   // peripheral block in memory space
  localparam int unsigned MPA_WHOLE_MID_BIT = 5;   // first select covers whole block
  localparam int unsigned MIDC_SIZE_LSB     = 8;   // size code [10:8]
  localparam int unsigned MIDC_GP_LSB       = 12;  // free-pin levels [14:12]
  localparam int unsigned MID_GRAIN_BITS    = 13;  // 8 KB base granularity
  localparam int unsigned PER_BLOCK_BITS    = 11;  // 2 KB peripheral block
  localparam int unsigned PER_REGION_BITS   = 8;   // 256-byte region

  // reset values
  localparam logic [15:0] AUX_RST  = 16'h0000;
  localparam logic [15:0] RFC_RST  = 16'h0000;
  localparam logic [15:0] MPA_RST  = 16'h0080;
  localparam logic [15:0] MIDC_RST = 16'h0000;
  localparam logic [15:0] PERC_RST = 16'h0000;

  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one bus cycle as offered by the bus unit at its address phase
  typedef struct packed {
    logic [19:0] addr;  // physical address, i/o uses the low 16 bits
    logic        io;    // 1: i/o space, 0: memory space
    logic        read;  // 1: read cycle
  } cyc_req_t;

  // bus cycle sequencer, gray on every step but data-idle
  typedef enum logic [1:0] {
    CYC_IDLE = 2'h0,
    CYC_ADDR = 2'h1,
    CYC_DATA = 2'h3,
    CYC_HOLD = 2'h2
  } cyc_state_t;

  // active-low select set; peripheral index is the region number
  typedef struct packed {
    logic [3:0] mid_n;
    logic [7:0] periph_n;
  } selects_t;

  localparam selects_t SEL_IDLE = '{mid_n: 4'hF, periph_n: 8'hFF};

endpackage
`default_nettype wire

// File: refresh_pulse_gen.sv
// refresh pulse timer for pseudo-static and dynamic memory
// assumes aclk, with the bus clock derived here as a one-cycle enable
`default_nettype none
module refresh_pulse_gen #(
  parameter int unsigned IVL_W  = csu_pkg::RFC_IVL_W,
  parameter int unsigned ACTIVE = csu_pkg::RFSH_ACTIVE_CYCLES
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             enable,
  input  wire logic [IVL_W-1:0] interval,
  output logic                  refresh_n
);
  import csu_pkg::*;

  // pulse counter must hold ACTIVE and at least two cycles
  if (ACTIVE < 2 || ACTIVE > 7 || IVL_W < 1) begin : g_bad_param
    $error("refresh_pulse_gen: unsupported parameters");
  end

  typedef struct packed {
    logic             div;    // bus clock phase
    logic [IVL_W-1:0] ivl;    // bus clocks to next pulse
    logic [2:0]       act;    // remaining low cycles
    logic             pin_n;  // refresh output
  } rfsh_state_t;

  rfsh_state_t r;  // registered state
  rfsh_state_t n;  // next state

  // interval count on the bus clock enable, pulse timed in aclk cycles
  always_comb begin
    n = r;
    n.div = ~r.div;
    if (!enable) begin
      // mode off: keep pin idle high
      n.ivl   = interval;
      n.act   = 3'h0;
      n.pin_n = 1'b1;
    end else if (r.act != 3'h0) begin
      // inside the pulse; rise on the last count
      n.act   = r.act - 3'h1;
      n.pin_n = (r.act == 3'h1);
    end else if (r.div) begin
      if (r.ivl == '0) begin
        // interval spent: start a pulse, reload the wait
        n.ivl   = interval;
        n.act   = 3'(ACTIVE);  // low for ACTIVE cycles, last count raises the pin
        n.pin_n = 1'b0;
      end else begin
        n.ivl = r.ivl - 1'b1;
      end
    end
  end

  // single register bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{div: 1'b0, ivl: '0, act: 3'h0, pin_n: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign refresh_n = r.pin_n;

  // three aclk cycles low, i.e. one and a half bus clocks
  a_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn || !enable)
    $fell(refresh_n) |-> !refresh_n ##1 !refresh_n ##1 !refresh_n ##1 refresh_n)
    else $error("refresh pulse width wrong");

  // nothing is emitted while the mode bit is clear
  a_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> refresh_n)
    else $error("refresh pulse without mode bit");

endmodule // refresh_pulse_gen
`default_nettype wire

// File: chip_select_unit.sv
// midrange and peripheral chip selects, refresh pin, latched address bits, read strobe
// assumes the bus unit finishes a cycle before granting hold, on the same clock
//
// How it works
// - first midrange select marks first region, whole block in whole-range mode
// - second and third selects mark regions two, three
// - fourth select marks fourth midrange region
// - midrange width follows aux config bit one
// - midrange selects held high during bus hold
// - whole-range mode frees other three pins
// - refresh pulse only when mode bit set
// - refresh low one and half bus clocks
// - refresh pin keeps driving during hold
// - peripheral selects mark regions 1-4, 6, 7
// - 256-byte regions, asserted with address phase
// - peripheral selects high in reset and hold
// - option bit zero puts latched address out
// - latched address bits frozen across hold
// - read strobe only after bus floated
// - read strobe floats while hold granted
// - on hold release bus, then selects high
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none
module chip_select_unit #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  input  wire logic              cyc_start,
  input  wire csu_pkg::cyc_req_t cyc_req,
  input  wire logic              ad_floated,
  input  wire logic              cyc_end,
  input  wire logic              hold_grant,
  output logic                   mid_select_first,
  output logic                   mid_select_second,
  output logic                   mid_select_third,
  output logic                   mid_select_fourth,
  output logic                   periph_select_first,
  output logic                   periph_select_second,
  output logic                   periph_select_third,
  output logic                   periph_select_fourth,
  output logic                   periph_select_sixth,
  output logic                   periph_select_seventh,
  output logic                   rd_strobe_n,
  output logic                   rd_strobe_oe_n,
  output logic                   mid_bus_wide
);
  import csu_pkg::*;

  // the map needs one byte of address
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_param
    $error("chip_select_unit: ADDR_W must be 8..32");
  end

  typedef struct packed {
    cyc_state_t  st;        // bus cycle sequencer
    logic        cur_read;  // current cycle is a read
    selects_t    sel;       // decoded selects of this cycle
    logic [1:0]  lat_addr;  // latched address bits 2:1
    logic [3:0]  mid_pin;   // midrange pin levels
    logic [5:0]  per_pin;   // peripheral pins 7,6,4,3,2,1
    logic        rd_n;      // read strobe level
    logic        rd_oe_n;   // read strobe enable, low drives
    logic        wide;      // midrange 16-bit width
    logic [15:0] aux;       // aux_config_reg
    logic [15:0] rfc;       // refresh_control_reg
    logic [15:0] mpa;       // mid_periph_aux_reg
    logic [15:0] midc;      // midrange base, size, free-pin levels
    logic [15:0] perc;      // peripheral base
    logic        awready;   // write address slot open
    logic        wready;    // write data slot open
    logic        aw_have;   // write address captured
    logic        w_have;    // write data captured
    logic [7:0]  waddr;     // captured write offset
    logic [31:0] wdat;      // captured write data
    logic [3:0]  wstb;      // captured byte enables
    logic        bvalid;    // write response pending
    logic [1:0]  bresp;     // write response code
    logic        arready;   // read address slot open
    logic        rvalid;    // read data pending
    logic [1:0]  rresp;     // read response code
    logic [31:0] rdata;     // read data
  } csu_state_t;

  localparam csu_state_t RST_STATE = '{
    st: CYC_IDLE, sel: SEL_IDLE, mid_pin: 4'hF, per_pin: 6'h3F,
    rd_n: 1'b1, aux: AUX_RST, rfc: RFC_RST, mpa: MPA_RST, midc: MIDC_RST,
    perc: PERC_RST, awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0
  };

  csu_state_t r;          // registered state
  csu_state_t n;          // next state
  selects_t   dec;        // decode of the offered address
  logic       refresh_n;  // refresh timer output

  // address decoder; midrange wins where the blocks overlap
  function automatic selects_t decode(input cyc_req_t q, input logic [15:0] midc,
                                      input logic [15:0] perc, input logic [15:0] mpa);
    selects_t    s;
    logic [2:0]  code;
    logic [6:0]  mask;
    logic [19:0] off;
    logic [1:0]  reg_ix;
    s      = SEL_IDLE;
    code   = midc[MIDC_SIZE_LSB +: 3];
    mask   = 7'h7F << code;
    off    = q.addr - {midc[6:0], 13'h0000};
    reg_ix = 2'(off >> (32'(code) + MID_GRAIN_BITS - 2));
    if (!q.io && ((q.addr[19:MID_GRAIN_BITS] ^ midc[6:0]) & mask) == 7'h00) begin
      if (mpa[MPA_WHOLE_MID_BIT]) begin
        s.mid_n[0] = 1'b0;
      end else begin
        s.mid_n[reg_ix] = 1'b0;
      end
    end else if ((q.io != mpa[MPA_PER_MEM_BIT])
                 && q.addr[19:PER_BLOCK_BITS] == perc[8:0]) begin
      // 256-byte regions; fifth and eighth have no pin
      s.periph_n[q.addr[PER_BLOCK_BITS-1:PER_REGION_BITS]] = 1'b0;
    end
    return s;
  endfunction

  // 16-bit register write under byte enables
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // refresh timer drives the shared fourth midrange pin
  refresh_pulse_gen #(
    .IVL_W  (RFC_IVL_W),
    .ACTIVE (RFSH_ACTIVE_CYCLES)
  ) u_refresh (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (r.rfc[RFC_MODE_BIT]),
    .interval  (r.rfc[RFC_IVL_W-1:0]),
    .refresh_n (refresh_n)
  );

  assign dec = decode(cyc_req, r.midc, r.perc, r.mpa);

  // next state: cycle sequencer, register slave, pin muxing
  always_comb begin
    n = r;

    // bus cycle sequencer
    case (r.st)
      CYC_IDLE: begin
        if (hold_grant) begin
          // float the strobe first; selects go high in hold state
          n.st      = CYC_HOLD;
          n.rd_n    = 1'b1;
          n.rd_oe_n = 1'b1;
        end else if (cyc_start) begin
          // selects come out with the address phase
          n.st       = CYC_ADDR;
          n.sel      = dec;
          n.cur_read = cyc_req.read;
          n.lat_addr = cyc_req.addr[2:1];
        end
      end
      CYC_ADDR: begin
        if (cyc_end) begin
          n.st  = CYC_IDLE;
          n.sel = SEL_IDLE;
        end else if (ad_floated) begin
          // strobe waits for the bus turnaround
          n.st   = CYC_DATA;
          n.rd_n = ~r.cur_read;
        end
      end
      CYC_DATA: begin
        if (cyc_end) begin
          n.st   = CYC_IDLE;
          n.sel  = SEL_IDLE;
          n.rd_n = 1'b1;
        end
      end
      CYC_HOLD: begin
        n.sel = SEL_IDLE;
        if (!hold_grant) begin
          // take the strobe back
          n.st      = CYC_IDLE;
          n.rd_oe_n = 1'b0;
        end
      end
      default: begin
        n.st = CYC_IDLE;
      end
    endcase

    // write address and data accepted in either order
    if (awvalid && r.awready) begin
      n.awready = 1'b0;
      n.aw_have = 1'b1;
      n.waddr   = awaddr[7:0];
    end
    if (wvalid && r.wready) begin
      n.wready = 1'b0;
      n.w_have = 1'b1;
      n.wdat   = wdata;
      n.wstb   = wstrb;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      // both halves present: commit and answer
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      if (r.waddr == OFS_AUX_CONFIG) begin
        n.aux = merge(r.aux, r.wdat, r.wstb);
      end else if (r.waddr == OFS_REFRESH_CTRL) begin
        n.rfc = merge(r.rfc, r.wdat, r.wstb);
      end else if (r.waddr == OFS_MID_PERIPH) begin
        n.mpa = merge(r.mpa, r.wdat, r.wstb);
      end else if (r.waddr == OFS_MID_CFG) begin
        n.midc = merge(r.midc, r.wdat, r.wstb);
      end else if (r.waddr == OFS_PERIPH_CFG) begin
        n.perc = merge(r.perc, r.wdat, r.wstb);
      end else if (r.waddr != OFS_STATUS) begin
        n.bresp = RESP_SLVERR;  // unmapped
      end
    end
    if (r.bvalid && bready) begin
      // reopen both slots only after the answer is taken
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // read channel, one outstanding
    if (arvalid && r.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = RESP_OKAY;
      n.rdata   = 32'h0000_0000;
      if (araddr[7:0] == OFS_AUX_CONFIG) begin
        n.rdata[15:0] = r.aux;
      end else if (araddr[7:0] == OFS_REFRESH_CTRL) begin
        n.rdata[15:0] = r.rfc;
      end else if (araddr[7:0] == OFS_MID_PERIPH) begin
        n.rdata[15:0] = r.mpa;
      end else if (araddr[7:0] == OFS_MID_CFG) begin
        n.rdata[15:0] = r.midc;
      end else if (araddr[7:0] == OFS_PERIPH_CFG) begin
        n.rdata[15:0] = r.perc;
      end else if (araddr[7:0] == OFS_STATUS) begin
        // live view of the block
        n.rdata[15:0] = {r.lat_addr, r.st, r.mid_pin, r.sel.periph_n};
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end
    if (r.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // pin levels, registered so every output leaves a flip-flop
    n.wide    = n.aux[AUX_MID_WIDE_BIT];
    n.mid_pin = n.sel.mid_n;
    if (n.mpa[MPA_WHOLE_MID_BIT]) begin
      // spare pins follow software levels
      n.mid_pin[3:1] = n.midc[MIDC_GP_LSB +: 3];
    end
    if (n.rfc[RFC_MODE_BIT]) begin
      // refresh owns the pin, hold or not
      n.mid_pin[3] = refresh_n;
    end
    n.per_pin = {n.sel.periph_n[6:5], n.sel.periph_n[3:0]};
    if (!n.mpa[MPA_LATCH_OPT_BIT]) begin
      n.per_pin[5:4] = n.lat_addr;
    end
  end

  // single register bank; reset parks every select high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the register bank
  assign awready               = r.awready;
  assign wready                = r.wready;
  assign bvalid                = r.bvalid;
  assign bresp                 = r.bresp;
  assign arready               = r.arready;
  assign rvalid                = r.rvalid;
  assign rdata                 = r.rdata;
  assign rresp                 = r.rresp;
  assign mid_select_first      = r.mid_pin[0];
  assign mid_select_second     = r.mid_pin[1];
  assign mid_select_third      = r.mid_pin[2];
  assign mid_select_fourth     = r.mid_pin[3];
  assign periph_select_first   = r.per_pin[0];
  assign periph_select_second  = r.per_pin[1];
  assign periph_select_third   = r.per_pin[2];
  assign periph_select_fourth  = r.per_pin[3];
  assign periph_select_sixth   = r.per_pin[4];
  assign periph_select_seventh = r.per_pin[5];
  assign rd_strobe_n           = r.rd_n;
  assign rd_strobe_oe_n        = r.rd_oe_n;
  assign mid_bus_wide          = r.wide;

  // first midrange select high after two cycles of hold, second and third too outside whole-range mode
  a_hold_mid_high: assert property (@(posedge aclk) disable iff (!aresetn)
    hold_grant [*3] |-> mid_select_first
      && (r.mpa[MPA_WHOLE_MID_BIT] || (mid_select_second && mid_select_third)))
    else $error("midrange select low during hold");

  // first to fourth peripheral selects high after two cycles of hold
  a_hold_per_high: assert property (@(posedge aclk) disable iff (!aresetn)
    hold_grant [*3] |-> periph_select_first && periph_select_second
      && periph_select_third && periph_select_fourth)
    else $error("peripheral select low during hold");

  // strobe floated one cycle into hold
  a_hold_rd_float: assert property (@(posedge aclk) disable iff (!aresetn)
    hold_grant ##1 hold_grant |-> rd_strobe_oe_n && rd_strobe_n)
    else $error("read strobe driven during hold");

  // strobe falls only after the bus has floated in a read
  a_rd_after_float: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(rd_strobe_n) |-> $past(ad_floated) && $past(r.st) == CYC_ADDR && $past(r.cur_read))
    else $error("read strobe before bus floated");

  // never two selects at once
  a_sel_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(~{r.sel.mid_n, r.sel.periph_n}))
    else $error("more than one select active");

  // selects follow the decode of the address phase
  a_sel_at_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.st == CYC_IDLE && cyc_start && !hold_grant) |=> r.st == CYC_ADDR && r.sel == $past(dec))
    else $error("selects not taken with address phase");

  // latched address bits frozen through hold
  a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    hold_grant ##1 hold_grant |-> $stable(r.lat_addr))
    else $error("latched address changed during hold");

  // refresh pin carries the timer in refresh mode, hold included
  a_refresh_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    r.rfc[RFC_MODE_BIT] |-> mid_select_fourth == $past(refresh_n))
    else $error("refresh pin not driven by timer");

endmodule // chip_select_unit
`default_nettype wire

// File: mem_side_model.sv
// far-side memories and peripherals watching the local bus selects
// assumes active-low selects sampled on aclk, pins packed first..seventh
`default_nettype none
module mem_side_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [9:0] pins,       // mid 1..4, periph 1..4, 6, 7
  input  wire logic       lat_mode,   // last two pins carry address bits
  input  wire logic       rfsh_mode,  // fourth mid pin is refresh
  output logic            multi_sel   // sticky: two devices selected
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] act;  // devices that see their select
  assign act = ~pins & {3'h7, ~rfsh_mode, 4'hF, ~lat_mode, ~lat_mode};
  // two devices at once would fight on the data bus
  always_ff @(posedge aclk) begin
    if (!aresetn) multi_sel <= 1'b0;
    else if ($countones(act) > 1) multi_sel <= 1'b1;
  end
endmodule  // mem_side_model
`default_nettype wire

// File: tb.sv
// self-checking bench for the chip select unit
// assumes csu_pkg compiled first; bench acts as bus unit and axi master
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csu_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cyc_start, ad_floated, cyc_end;
  logic        hold_grant, rd_strobe_n, rd_strobe_oe_n, mid_bus_wide, multi_sel;
  logic        mid_select_first, mid_select_second, mid_select_third, mid_select_fourth;
  logic        periph_select_first, periph_select_second, periph_select_third;
  logic        periph_select_fourth, periph_select_sixth, periph_select_seventh;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;  // rd_d: data of last read
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;   // rsp: answer of last access
  logic        lat, rfsh;           // bench view of pin modes
  logic [19:0] a;
  cyc_req_t    cyc_req;
  int          miscompares, num_checks, lo;
  wire logic [9:0] pins = {mid_select_first, mid_select_second, mid_select_third,
    mid_select_fourth, periph_select_first, periph_select_second, periph_select_third,
    periph_select_fourth, periph_select_sixth, periph_select_seventh};
  chip_select_unit #(.ADDR_W(8)) chip_select_unit_i (.*);
  mem_side_model mem_side_model_i (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .lat_mode(lat), .rfsh_mode(rfsh), .multi_sel(multi_sel));
  // value compare, four-state exact
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // axi write; aw and w offered together, each dropped when taken
  task wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= ad;
    wdata <= {16'h0000, d};
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task rd(input logic [7:0] ad);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= ad;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rd_d = rdata;
    rsp = rresp;
  endtask
  // pins between cycles; latched bits show when enabled
  function automatic logic [9:0] idle_of(input logic [19:0] x);
    return {8'hFF, lat ? {x[1], x[2]} : 2'b11};
  endfunction
  // expected pins during a cycle: mid block 0x40000, periph block 0x08000
  function automatic logic [9:0] exp_sel(input logic [19:0] x);
    logic [9:0] e;
    int         r;
    e = idle_of(x);
    r = int'(x[10:8]);
    if (x[19:13] == 7'h20) e[9 - int'(x[12:11])] = 1'b0;
    else if (x[19:11] == 9'h010 && r != 4 && r != 7 && !(lat && r > 4))
      e[r < 4 ? 5 - r : 6 - r] = 1'b0;
    return e;
  endfunction
  // one memory cycle: start, float, end
  task bus(input logic [19:0] x, input logic rdc, input logic [9:0] e);
    @(posedge aclk);
    cyc_start <= 1'b1;
    cyc_req <= '{addr: x, io: 1'b0, read: rdc};
    @(posedge aclk);
    cyc_start <= 1'b0;
    @(posedge aclk);
    ad_floated <= rdc;
    #1 chk(32'(pins), 32'(e));
    chk(32'(rd_strobe_n), 32'h1);
    @(posedge aclk);
    ad_floated <= 1'b0;
    cyc_end <= 1'b1;
    #1 chk(32'(rd_strobe_n), 32'(!rdc));
    @(posedge aclk);
    cyc_end <= 1'b0;
    #1 chk(32'(pins), 32'(idle_of(x)));
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // watchdog: whole run is a few hundred cycles
  initial begin
    #300us;
    miscompares++;
    end_sim;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cyc_start} = '0;
    {ad_floated, cyc_end, hold_grant, lat, rfsh} = '0;
    {awaddr, araddr, wdata, cyc_req} = '0;
    wstrb = 4'hF;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(54178));
    repeat (3) @(posedge aclk);
    #1 chk(32'(pins), 32'h3FF);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08);
    chk(rd_d, 32'h80);
    chk(32'(rsp), 32'(RESP_OKAY));
    rd(8'h14);
    chk(rd_d, 32'h0FFF);
    rd(8'h40);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(8'h00, 16'h0002);
    #1 chk(32'(mid_bus_wide), 32'h1);
    chk(32'(rsp), 32'(RESP_OKAY));
    // unmapped write refused, width bit untouched
    wr(8'h18, 16'h0000);
    chk(32'(rsp), 32'(RESP_SLVERR));
    #1 chk(32'(mid_bus_wide), 32'h1);
    wr(8'h0C, 16'h0020);
    rd(8'h0C);
    chk(rd_d, 32'h0020);
    wr(8'h10, 16'h0010);
    wr(8'h08, 16'h00C0);
    // every mid region, every periph region, then random traffic
    for (int i = 0; i < 4; i++) bus({7'h20, 2'(i), 11'h155}, 1'b1, exp_sel({7'h20, 2'(i), 11'h155}));
    for (int i = 0; i < 8; i++) bus({9'h010, 3'(i), 8'h3C}, 1'b0, exp_sel({9'h010, 3'(i), 8'h3C}));
    repeat (16) begin
      lo = int'($urandom % 3);
      a = lo == 0 ? {7'h20, 13'($urandom)} : lo == 1 ? {9'h010, 11'($urandom)} : {4'hC, 16'($urandom)};
      bus(a, 1'($urandom), exp_sel(a));
    end
    // latched address bits, then frozen through hold
    // model masks the two pins before they turn into address bits
    lat <= 1'b1;
    wr(8'h08, 16'h0040);
    bus(20'h08504, 1'b1, exp_sel(20'h08504));
    @(posedge aclk);
    hold_grant <= 1'b1;
    @(posedge aclk);
    cyc_start <= 1'b1;
    cyc_req <= '{addr: 20'h40002, io: 1'b0, read: 1'b1};
    #1 chk(32'(rd_strobe_oe_n), 32'h1);
    @(posedge aclk);
    cyc_start <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 chk(32'(pins), 32'(idle_of(20'h08504)));
    // refresh pulse keeps running in hold
    wr(8'h04, 16'h8002);
    rfsh <= 1'b1;
    for (lo = 0; lo < 40 && mid_select_fourth; lo++) @(posedge aclk);
    for (lo = 0; lo < 9 && !mid_select_fourth; lo++) @(posedge aclk);
    chk(32'(lo), 32'h3);
    hold_grant <= 1'b0;
    wr(8'h04, 16'h0002);
    rfsh <= 1'b0;
    repeat (4) @(posedge aclk);
    lo = 0;
    repeat (30) begin
      @(posedge aclk);
      if (!mid_select_fourth) lo++;
    end
    chk(32'(lo), 32'h0);
    chk(32'(rd_strobe_oe_n), 32'h0);
    // whole-range mode: first select only, freed pins at level 1
    wr(8'h0C, 16'h7020);
    wr(8'h08, 16'h00E0);
    lat <= 1'b0;
    bus(20'h41B00, 1'b1, 10'h1FF);
    chk(32'(multi_sel), 32'h0);
    end_sim;
  end
endmodule  // tb
`default_nettype wire
